// >>> logic/tpw_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "tpw_regs.vh"

// Summary of operation
// - capture top written directly, no buffering
// - compare writes go to a buffer
// - fast mode loads compare at top
// - field two non-inverted, three inverted
// - pin follows channel only when direction set
// - fast: set on match, clear at wrap
// - prescale 1,8,64,256,1024 plus 16,32
// - fast extremes: bottom spike, top constant
// - mode 15 channel A toggle on match
// - modes 1,2,3,10,11 are phase correct
// - phase correct tops; hold top one cycle
// - dual slope: clear up-match, set down-match
// - phase correct overflow at bottom
// - register top flag at top, with load there except in modes 8 and 12
// - fixed top masks written compare bits
// - phase correct extremes: bottom low, top high
// - mode 11 channel A toggles
// - modes 8,9 are phase frequency correct
// - compare flag on a tick when count equals compare
// - register top from 0x0003 to max
// - modes 5,6,7,14,15 are fast PWM
// - fast overflow at top; top flag at top in mode 14 only
// - frequency correct loads compare at bottom
module tpw_timer (
	input  wire        sys_clk,
	input  wire        arst_n,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	output reg         chan_a_pin_q,
	output reg         chan_a_oe_n_q,
	output reg         chan_b_pin_q,
	output reg         chan_b_oe_n_q
);

	// bus state
	reg                  wr_pend_q;
	reg  [5:0]           wr_addr_q;

	// timer state
	reg  [`TPW_CTRL_W-1:0] ctrl_q;
	reg  [15:0]          cnt_q;
	reg                  dir_down_q;
	reg  [15:0]          cap_q;
	reg  [3:0]           flags_q;
	reg  [3:0]           flags_d;
	reg  [15:0]          top;
	reg                  fixed_top;
	reg  [31:0]          rd_val;

	wire [3:0]           wmode;
	wire [1:0]           com_a;
	wire [1:0]           com_b;
	wire [2:0]           clk_sel;
	wire                 tick;
	wire                 fast;
	wire                 pc;
	wire                 pfc;
	wire                 ctc;
	wire                 dual;
	wire                 pwm;
	wire                 top_is_cap;
	wire                 top_is_a;
	wire                 at_top;
	wire                 at_bottom;
	wire                 up_eff;
	wire                 wrap;
	wire                 load;
	wire                 ovf_set;
	wire                 cap_set;
	wire                 wr_ctrl;
	wire                 wr_cnt;
	wire                 wr_a;
	wire                 wr_b;
	wire                 wr_cap;
	wire                 wr_flg;
	wire [15:0]          wmask;
	wire [15:0]          cmp_a;
	wire [15:0]          cmp_b;
	wire [15:0]          buf_a;
	wire [15:0]          buf_b;
	wire                 hit_a;
	wire                 hit_b;
	wire                 out_a;
	wire                 out_b;
	wire                 addr_ok;
	wire                 in_map;
	wire                 norm_wrap;

	assign wmode   = ctrl_q[`TPW_WMODE_LSB+3:`TPW_WMODE_LSB];
	assign com_a   = ctrl_q[`TPW_COMA_LSB+1:`TPW_COMA_LSB];
	assign com_b   = ctrl_q[`TPW_COMB_LSB+1:`TPW_COMB_LSB];
	assign clk_sel = ctrl_q[`TPW_CSEL_LSB+2:`TPW_CSEL_LSB];

	// mode decode
	assign fast = (wmode == 4'h5) || (wmode == 4'h6) || (wmode == 4'h7) ||
		(wmode == 4'hE) || (wmode == 4'hF);
	assign pc   = (wmode == 4'h1) || (wmode == 4'h2) || (wmode == 4'h3) ||
		(wmode == 4'hA) || (wmode == 4'hB);
	assign pfc  = (wmode == 4'h8) || (wmode == 4'h9);
	assign ctc  = (wmode == 4'h4) || (wmode == 4'hC);
	assign dual = pc || pfc;
	assign pwm  = fast || dual;

	assign top_is_cap = (wmode == 4'hA) || (wmode == 4'hE) ||
		(wmode == 4'h8) || (wmode == 4'hC);
	assign top_is_a   = (wmode == 4'hB) || (wmode == 4'hF) ||
		(wmode == 4'h9) || (wmode == 4'h4);

	// register tops take any value; software keeps it 0x0003 or above
	always @* begin
		fixed_top = 1'b1;
		case (wmode)
			4'h1, 4'h5: top = `TPW_TOP8;
			4'h2, 4'h6: top = `TPW_TOP9;
			4'h3, 4'h7: top = `TPW_TOP10;
			default: begin
				fixed_top = 1'b0;
				if (top_is_cap)
					top = cap_q;
				else if (top_is_a)
					top = cmp_a;
				else
					top = `TPW_MAX;
			end
		endcase
	end

	// equality only: a top written below the count is missed until wrap
	assign at_top    = (cnt_q == top);
	assign at_bottom = (cnt_q == `TPW_BOTTOM);
	// bottom counts as rising, top as falling, giving the steady extremes
	assign up_eff    = at_bottom || (!dir_down_q && !at_top);
	assign wrap      = tick && fast && at_top;
	assign load      = tick && ((fast && at_top) ||
		(pc && at_top && !dir_down_q) ||
		(pfc && at_bottom));

	// normal mode overflows at max; a ctc top below max clears first
	assign norm_wrap = !pwm && (cnt_q == `TPW_MAX);
	assign ovf_set   = tick && ((fast && at_top) ||
		(dual && dir_down_q && at_bottom) ||
		norm_wrap);
	assign cap_set = tick && top_is_cap && at_top;

	// bus: address phase captured, writes land in the data phase
	assign addr_ok = hsel && hready && htrans[1];
	// only haddr[7:0] decodes, so the map repeats every 256 bytes; writes above the low 64 within it are dropped
	assign in_map  = (haddr[7:6] == 2'b00);

	assign wr_ctrl = wr_pend_q && (wr_addr_q == `TPW_OFF_CTRL);
	assign wr_cnt  = wr_pend_q && (wr_addr_q == `TPW_OFF_COUNT);
	assign wr_a    = wr_pend_q && (wr_addr_q == `TPW_OFF_CMP_A);
	assign wr_b    = wr_pend_q && (wr_addr_q == `TPW_OFF_CMP_B);
	assign wr_cap  = wr_pend_q && (wr_addr_q == `TPW_OFF_CAPTOP);
	assign wr_flg  = wr_pend_q && (wr_addr_q == `TPW_OFF_FLAGS);

	assign wmask = fixed_top ? (hwdata[15:0] & top) : hwdata[15:0];

	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 6'h00;
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend_q <= addr_ok && hwrite && in_map;
			if (addr_ok)
				wr_addr_q <= {haddr[5:2], 2'b00};
			if (addr_ok && !hwrite)
				hrdata <= rd_val;
		end
	end

	always @* begin
		rd_val = 32'h00000000;
		case ({haddr[7:2], 2'b00} & 8'hFF)
			{2'b00, `TPW_OFF_CTRL}:   rd_val[`TPW_CTRL_W-1:0] = ctrl_q;
			{2'b00, `TPW_OFF_COUNT}:  rd_val[15:0] = cnt_q;
			{2'b00, `TPW_OFF_CMP_A}:  rd_val[15:0] = buf_a;
			{2'b00, `TPW_OFF_CMP_B}:  rd_val[15:0] = buf_b;
			{2'b00, `TPW_OFF_CAPTOP}: rd_val[15:0] = cap_q;
			{2'b00, `TPW_OFF_FLAGS}:  rd_val[3:0] = flags_q;
			{2'b00, `TPW_OFF_STATUS}: rd_val[2:0] = {out_b, out_a, dir_down_q};
			default:                  rd_val = 32'h00000000;
		endcase
	end

	// control and capture top
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= `TPW_CTRL_RST;
			cap_q  <= 16'h0000;
		end else begin
			if (wr_ctrl)
				ctrl_q <= hwdata[`TPW_CTRL_W-1:0];
			if (wr_cap)
				cap_q <= hwdata[15:0];
		end
	end

	// counter: software write takes precedence over the tick
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q      <= 16'h0000;
			dir_down_q <= 1'b0;
		end else if (wr_cnt) begin
			cnt_q <= hwdata[15:0];
		end else if (tick) begin
			// bottom also lasts one tick, so a dual period is twice top
			if (dual) begin
				if (!dir_down_q) begin
					if (at_top) begin
						dir_down_q <= 1'b1;
						cnt_q      <= cnt_q - 16'h0001;
					end else begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end else if (at_bottom) begin
					dir_down_q <= 1'b0;
					cnt_q      <= cnt_q + 16'h0001;
				end else begin
					cnt_q <= cnt_q - 16'h0001;
				end
			end else begin
				dir_down_q <= 1'b0;
				if ((fast || ctc) && at_top)
					cnt_q <= `TPW_BOTTOM;
				else
					cnt_q <= cnt_q + 16'h0001;
			end
		end
	end

	// sticky flags: write one to clear, a new event in the same cycle wins
	always @* begin
		flags_d = flags_q;
		if (wr_flg)
			flags_d = flags_q & ~hwdata[3:0];
		if (ovf_set)
			flags_d[`TPW_FLG_OVF] = 1'b1;
		if (hit_a)
			flags_d[`TPW_FLG_CMPA] = 1'b1;
		if (hit_b)
			flags_d[`TPW_FLG_CMPB] = 1'b1;
		if (cap_set)
			flags_d[`TPW_FLG_CAP] = 1'b1;
	end

	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			flags_q <= 4'h0;
		else
			flags_q <= flags_d;
	end

	// tick is registered, so a new select acts two edges after the write
	tpw_prescale u_pre (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.clk_sel (clk_sel),
		.tick_q  (tick)
	);

	tpw_chan u_chan_a (
		.sys_clk   (sys_clk),
		.arst_n    (arst_n),
		.wr        (wr_a),
		.wdata     (wmask),
		.buffered  (pwm),
		.load      (load),
		.tick      (tick),
		.count     (cnt_q),
		.pwm       (pwm),
		.fast      (fast),
		.wrap      (wrap),
		.up_eff    (up_eff),
		.toggle_ok (top_is_a),
		.com       (com_a),
		.buf_q     (buf_a),
		.cmp_q     (cmp_a),
		.hit       (hit_a),
		.out_q     (out_a)
	);

	// channel B has no pwm toggle, so its field 1 holds the level
	tpw_chan u_chan_b (
		.sys_clk   (sys_clk),
		.arst_n    (arst_n),
		.wr        (wr_b),
		.wdata     (wmask),
		.buffered  (pwm),
		.load      (load),
		.tick      (tick),
		.count     (cnt_q),
		.pwm       (pwm),
		.fast      (fast),
		.wrap      (wrap),
		.up_eff    (up_eff),
		.toggle_ok (1'b0),
		.com       (com_b),
		.buf_q     (buf_b),
		.cmp_q     (cmp_b),
		.hit       (hit_b),
		.out_q     (out_b)
	);

	// pins: one flop after the waveform, enable low while driving
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			chan_a_pin_q  <= 1'b0;
			chan_a_oe_n_q <= 1'b1;
			chan_b_pin_q  <= 1'b0;
			chan_b_oe_n_q <= 1'b1;
		end else begin
			chan_a_pin_q  <= out_a;
			chan_a_oe_n_q <= !(ctrl_q[`TPW_DIRA_BIT] && com_a != `TPW_COM_OFF);
			chan_b_pin_q  <= out_b;
			chan_b_oe_n_q <= !(ctrl_q[`TPW_DIRB_BIT] && com_b != `TPW_COM_OFF);
		end
	end

endmodule // tpw_timer

`default_nettype wire

// >>> logic/tpw_regs.vh
`ifndef TPW_REGS_VH
`define TPW_REGS_VH

// register byte offsets
`define TPW_OFF_CTRL    6'h00
`define TPW_OFF_COUNT   6'h04
`define TPW_OFF_CMP_A   6'h08
`define TPW_OFF_CMP_B   6'h0C
`define TPW_OFF_CAPTOP  6'h10
`define TPW_OFF_FLAGS   6'h14
`define TPW_OFF_STATUS  6'h18

// control fields
`define TPW_CTRL_W       13
`define TPW_CTRL_RST     13'h0000
`define TPW_WMODE_LSB    0
`define TPW_COMA_LSB     4
`define TPW_COMB_LSB     6
`define TPW_CSEL_LSB     8
`define TPW_DIRA_BIT     11
`define TPW_DIRB_BIT     12

// flag bits
`define TPW_FLG_OVF      0
`define TPW_FLG_CMPA     1
`define TPW_FLG_CMPB     2
`define TPW_FLG_CAP      3

// output mode field values
`define TPW_COM_OFF      2'h0
`define TPW_COM_TOGGLE   2'h1
`define TPW_COM_CLEAR    2'h2
`define TPW_COM_SET      2'h3

// count limits
`define TPW_BOTTOM       16'h0000
`define TPW_MAX          16'hFFFF
`define TPW_TOP8         16'h00FF
`define TPW_TOP9         16'h01FF
`define TPW_TOP10        16'h03FF

// clock select codes and divide factors
`define TPW_CS_STOP      3'h0
`define TPW_CS_DIV1      3'h1
`define TPW_CS_DIV8      3'h2
`define TPW_CS_DIV64     3'h3
`define TPW_CS_DIV256    3'h4
`define TPW_CS_DIV1024   3'h5
`define TPW_CS_DIV16     3'h6
`define TPW_CS_DIV32     3'h7
`define TPW_PRE_W        10

`endif

// >>> logic/tpw_prescale.v
`timescale 1ns/1ps
`default_nettype none
`include "tpw_regs.vh"

module tpw_prescale (
	input  wire       sys_clk,
	input  wire       arst_n,
	input  wire [2:0] clk_sel,
	output reg        tick_q
);

	reg  [`TPW_PRE_W-1:0] div_q;
	reg                   tick_d;

	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_q  <= {`TPW_PRE_W{1'b0}};
			tick_q <= 1'b0;
		end else begin
			div_q  <= div_q + 1'b1;
			tick_q <= tick_d;
		end
	end

	// the free running divider is shared, so a new select may give one short period
	always @* begin
		case (clk_sel)
			`TPW_CS_DIV1:    tick_d = 1'b1;
			`TPW_CS_DIV8:    tick_d = &div_q[2:0];
			`TPW_CS_DIV16:   tick_d = &div_q[3:0];
			`TPW_CS_DIV32:   tick_d = &div_q[4:0];
			`TPW_CS_DIV64:   tick_d = &div_q[5:0];
			`TPW_CS_DIV256:  tick_d = &div_q[7:0];
			`TPW_CS_DIV1024: tick_d = &div_q[9:0];
			default:         tick_d = 1'b0;
		endcase
	end

endmodule // tpw_prescale

`default_nettype wire

// >>> logic/tpw_chan.v
`timescale 1ns/1ps
`default_nettype none
`include "tpw_regs.vh"

module tpw_chan (
	input  wire        sys_clk,
	input  wire        arst_n,
	input  wire        wr,
	input  wire [15:0] wdata,
	input  wire        buffered,
	input  wire        load,
	input  wire        tick,
	input  wire [15:0] count,
	input  wire        pwm,
	input  wire        fast,
	input  wire        wrap,
	input  wire        up_eff,
	input  wire        toggle_ok,
	input  wire [1:0]  com,
	output reg  [15:0] buf_q,
	output reg  [15:0] cmp_q,
	output wire        hit,
	output reg         out_q
);

	wire inv;

	assign hit = tick && (count == cmp_q);
	assign inv = com[0];

	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			buf_q <= 16'h0000;
			cmp_q <= 16'h0000;
		end else begin
			if (wr)
				buf_q <= wdata;
			if (buffered && load)
				cmp_q <= buf_q;
			else if (!buffered && wr)
				cmp_q <= wdata;
		end
	end

	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_q <= 1'b0;
		end else if (tick) begin
			if (pwm) begin
				if (toggle_ok && com == `TPW_COM_TOGGLE) begin
					if (hit)
						out_q <= ~out_q;
				end else if (com[1]) begin
					if (fast) begin
						// match beats wrap so compare equal to top holds the level
						if (hit)
							out_q <= ~inv;
						else if (wrap)
							out_q <= inv;
					end else if (hit) begin
						out_q <= up_eff ? inv : ~inv;
					end
				end
			end else if (hit) begin
				case (com)
					`TPW_COM_TOGGLE: out_q <= ~out_q;
					`TPW_COM_CLEAR:  out_q <= 1'b0;
					`TPW_COM_SET:    out_q <= 1'b1;
					default:         out_q <= out_q;
				endcase
			end
		end
	end

endmodule // tpw_chan

`default_nettype wire

// >>> sim/tpw_load.sv
`timescale 1ns/1ps
`default_nettype none
module tpw_load (
	input  wire logic        sys_clk,
	input  wire logic        pin,
	input  wire logic        oe_n,
	input  wire logic        clr,
	input  wire logic        run,
	output var  logic [15:0] hi_cnt,
	output var  logic [15:0] rise_cnt
);
	logic lvl;
	logic lvl_q;
	// pull-down load, so a released pin reads low
	assign lvl = oe_n ? 1'b0 : pin;
	always @(posedge sys_clk) begin
		lvl_q <= lvl;
		if (clr) begin
			hi_cnt   <= 16'h0000;
			rise_cnt <= 16'h0000;
		end else if (run) begin
			hi_cnt   <= hi_cnt + {15'h0000, lvl};
			rise_cnt <= rise_cnt + {15'h0000, lvl && !lvl_q};
		end
	end
endmodule // tpw_load
`default_nettype wire

// >>> sim/tpw_timer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpw_regs.vh"
module tpw_asserts (
	input wire logic        sys_clk,
	input wire logic        arst_n,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        chan_a_pin_q,
	input wire logic        chan_a_oe_n_q,
	input wire logic        chan_b_pin_q,
	input wire logic        chan_b_oe_n_q
);
	logic        w_q;
	logic [5:0]  a_q;
	logic [12:0] ctl_q;
	logic [15:0] cpa_q;
	logic [15:0] cpb_q;
	logic [15:0] top_q;
	logic [8:0]  st_q;
	// shadow of software writes; settle count restarts on every write
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			w_q   <= 1'b0;
			a_q   <= 6'h00;
			ctl_q <= 13'h0000;
			cpa_q <= 16'h0000;
			cpb_q <= 16'h0000;
			top_q <= 16'h0000;
			st_q  <= 9'h000;
		end else begin
			w_q  <= hsel && hready && htrans[1] && hwrite && haddr[7:6] == 2'h0;
			a_q  <= haddr[5:0];
			st_q <= w_q ? 9'h000 : ((st_q == 9'h1FF) ? st_q : st_q + 9'h001);
			if (w_q && a_q == `TPW_OFF_CTRL) ctl_q <= hwdata[12:0];
			if (w_q && a_q == `TPW_OFF_CMP_A) cpa_q <= hwdata[15:0];
			if (w_q && a_q == `TPW_OFF_CMP_B) cpb_q <= hwdata[15:0];
			if (w_q && a_q == `TPW_OFF_CAPTOP) top_q <= hwdata[15:0];
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	sequence s_run;
		st_q >= 9'd300 && ctl_q[10:8] == `TPW_CS_DIV1;
	endsequence
	sequence s_dual_b;
		s_run ##0 (ctl_q[3:0] == 4'hA || ctl_q[3:0] == 4'h8) && ctl_q[7] && top_q < 16'h0040;
	endsequence
	sequence s_rd_unmapped;
		hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'h3C;
	endsequence
	property p_oe_a;
		st_q >= 9'd2 |-> chan_a_oe_n_q == !(ctl_q[11] && ctl_q[5:4] != 2'h0);
	endproperty
	property p_oe_b;
		st_q >= 9'd2 |-> chan_b_oe_n_q == !(ctl_q[12] && ctl_q[7:6] != 2'h0);
	endproperty
	property p_stop;
		st_q >= 9'd4 && ctl_q[10:8] == `TPW_CS_STOP |=> $stable(chan_a_pin_q) && $stable(chan_b_pin_q);
	endproperty
	property p_fast_top;
		s_run ##0 ctl_q[3:0] == 4'hE && ctl_q[7] && cpb_q == top_q && top_q < 16'h0040
			|-> chan_b_pin_q == !ctl_q[6];
	endproperty
	property p_dual_lo;
		s_dual_b ##0 cpb_q == 16'h0000 |-> chan_b_pin_q == ctl_q[6];
	endproperty
	property p_dual_hi;
		s_dual_b ##0 cpb_q == top_q |-> chan_b_pin_q == !ctl_q[6];
	endproperty
	property p_tog_a;
		s_run ##0 (ctl_q[3:0] == 4'hF || ctl_q[3:0] == 4'hB) && ctl_q[5:4] == `TPW_COM_TOGGLE
			&& cpa_q < 16'h0008 |-> ##[1:16] $changed(chan_a_pin_q);
	endproperty
	property p_ready;
		$past(arst_n) |-> hreadyout && !hresp;
	endproperty
	property p_rd_zero;
		s_rd_unmapped |=> hrdata == 32'h0;
	endproperty
	a_oe_a: assert property (p_oe_a) else $error("pin A drive enable wrong");
	a_oe_b: assert property (p_oe_b) else $error("pin B drive enable wrong");
	a_stop: assert property (p_stop) else $error("pin moved with clock stopped");
	a_fast_top: assert property (p_fast_top) else $error("fast compare at top not constant");
	a_dual_lo: assert property (p_dual_lo) else $error("dual slope bottom level wrong");
	a_dual_hi: assert property (p_dual_hi) else $error("dual slope top level wrong");
	a_tog_a: assert property (p_tog_a) else $error("channel A toggle missing");
	a_ready: assert property (p_ready) else $error("bus not ready or error response");
	a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");
endmodule // tpw_asserts
bind tpw_timer tpw_asserts u_chk (
	.sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .chan_a_pin_q(chan_a_pin_q),
	.chan_a_oe_n_q(chan_a_oe_n_q), .chan_b_pin_q(chan_b_pin_q), .chan_b_oe_n_q(chan_b_oe_n_q)
);
`default_nettype wire

// >>> sim/tb_timer16_pwm_waveform_modes.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpw_regs.vh"
module tb_timer16_pwm_waveform_modes;
	logic        sys_clk;
	logic        arst_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        pin_a;
	logic        oe_n_a;
	logic        pin_b;
	logic        oe_n_b;
	logic        clr;
	logic        run;
	logic [15:0] hi_a;
	logic [15:0] ri_a;
	logic [15:0] hi_b;
	logic [15:0] ri_b;
	logic [31:0] rd;
	int          err_total;
	int          cmp_count;
	tpw_timer u_dut (
		.sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .chan_a_pin_q(pin_a), .chan_a_oe_n_q(oe_n_a),
		.chan_b_pin_q(pin_b), .chan_b_oe_n_q(oe_n_b)
	);
	tpw_load u_load_a (.sys_clk(sys_clk), .pin(pin_a), .oe_n(oe_n_a), .clr(clr), .run(run),
		.hi_cnt(hi_a), .rise_cnt(ri_a));
	tpw_load u_load_b (.sys_clk(sys_clk), .pin(pin_b), .oe_n(oe_n_b), .clr(clr), .run(run),
		.hi_cnt(hi_b), .rise_cnt(ri_b));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict;
		$display("mismatches %0d comparisons %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			err_total++;
			give_verdict;
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {26'h0, a};
		hwrite <= w;
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		rd = hrdata;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	function automatic logic [12:0] cw(input logic [3:0] m, input logic [1:0] ca,
		input logic [1:0] cb, input logic [2:0] cs);
		return {2'b11, cs, cb, ca, m};
	endfunction
	// compares are always kept at or below top
	task automatic measure(input logic [12:0] c, input logic [15:0] top, input logic [15:0] ca,
		input logic [15:0] cb, input logic ch, input int w, input logic [15:0] ehi,
		input logic [15:0] eri);
		wr(`TPW_OFF_CTRL, {19'h0, c});
		wr(`TPW_OFF_CAPTOP, {16'h0, top});
		wr(`TPW_OFF_CMP_A, {16'h0, ca});
		wr(`TPW_OFF_CMP_B, {16'h0, cb});
		wr(`TPW_OFF_COUNT, 32'h0);
		// long settle so buffered compares have loaded before the window
		repeat (w + 320) @(posedge sys_clk);
		clr <= 1'b1;
		@(posedge sys_clk);
		clr <= 1'b0;
		run <= 1'b1;
		repeat (w) @(posedge sys_clk);
		run <= 1'b0;
		@(posedge sys_clk);
		check("high cycles", {16'h0, ch ? hi_a : hi_b}, {16'h0, ehi});
		check("rising edges", {16'h0, ch ? ri_a : ri_b}, {16'h0, eri});
	endtask
	task automatic t_reset;
		check("ready", {31'h0, hreadyout}, 32'h1);
		check("oe pins", {30'h0, oe_n_a, oe_n_b}, 32'h3);
		bus(1'b0, `TPW_OFF_CTRL, 32'h0);
		check("ctrl reset", rd, 32'h0);
		bus(1'b0, 6'h3C, 32'h0);
		check("unmapped read", rd, 32'h0);
	endtask
	task automatic t_fast;
		measure(cw(4'hE, 2'h0, 2'h2, 3'h1), 16'h7, 16'h7, 16'h2, 1'b0, 64, 40, 8);
		measure(cw(4'hE, 2'h0, 2'h3, 3'h1), 16'h7, 16'h7, 16'h2, 1'b0, 64, 24, 8);
		measure(cw(4'hE, 2'h0, 2'h2, 3'h1), 16'h7, 16'h7, 16'h7, 1'b0, 64, 64, 0);
		measure(cw(4'h5, 2'h0, 2'h2, 3'h1), 16'h7, 16'h7, 16'h80, 1'b0, 512, 254, 2);
		measure(cw(4'hE, 2'h0, 2'h2, 3'h1) & 13'h0FFF, 16'h7, 16'h7, 16'h2, 1'b0, 64, 0, 0);
		check("oe b off", {31'h0, oe_n_b}, 32'h1);
	endtask
	task automatic t_dual;
		measure(cw(4'hA, 2'h0, 2'h2, 3'h1), 16'h8, 16'h8, 16'h2, 1'b0, 64, 16, 4);
		measure(cw(4'hA, 2'h0, 2'h3, 3'h1), 16'h8, 16'h8, 16'h2, 1'b0, 64, 48, 4);
		measure(cw(4'hA, 2'h0, 2'h2, 3'h1), 16'h8, 16'h8, 16'h0, 1'b0, 64, 0, 0);
		measure(cw(4'hA, 2'h0, 2'h2, 3'h1), 16'h8, 16'h8, 16'h8, 1'b0, 64, 64, 0);
		measure(cw(4'h8, 2'h0, 2'h2, 3'h1), 16'h8, 16'h8, 16'h2, 1'b0, 64, 16, 4);
		measure(cw(4'h1, 2'h0, 2'h2, 3'h1), 16'h8, 16'h8, 16'h80, 1'b0, 1020, 512, 2);
	endtask
	task automatic t_tog;
		measure(cw(4'hF, 2'h1, 2'h0, 3'h1), 16'h7, 16'h3, 16'h0, 1'b1, 64, 32, 8);
		measure(cw(4'hB, 2'h1, 2'h0, 3'h1), 16'h7, 16'h4, 16'h0, 1'b1, 64, 32, 4);
		// non-pwm match actions: ctc toggle, ctc set, normal clear
		measure(cw(4'h4, 2'h1, 2'h0, 3'h1), 16'h7, 16'h3, 16'h0, 1'b1, 64, 32, 8);
		measure(cw(4'hC, 2'h0, 2'h3, 3'h1), 16'h7, 16'h7, 16'h2, 1'b0, 64, 64, 0);
		measure(cw(4'h0, 2'h0, 2'h2, 3'h1), 16'h7, 16'h7, 16'h2, 1'b0, 64, 0, 0);
	endtask
	task automatic t_pre;
		int n_tab [7] = '{1, 8, 64, 256, 1024, 16, 32};
		for (int i = 0; i < 7; i++) begin
			measure(cw(4'hE, 2'h0, 2'h2, 3'(i + 1)), 16'h3, 16'h3, 16'h2, 1'b0, 8 * n_tab[i],
				16'(2 * n_tab[i]), 2);
		end
	endtask
	task automatic t_flags;
		logic [3:0] m_tab [6] = '{4'hE, 4'hF, 4'hA, 4'hB, 4'h8, 4'h9};
		for (int i = 0; i < 6; i++) begin
			// dual slope period is 14 here, so its window spans two periods
			measure(cw(m_tab[i], 2'h2, 2'h2, 3'h1), 16'h7, 16'h7, 16'h1, 1'b0,
				i < 2 ? 16 : 28, 16'(i < 2 ? 12 : 4), 2);
			wr(`TPW_OFF_FLAGS, 32'hF);
			repeat (40) @(posedge sys_clk);
			bus(1'b0, `TPW_OFF_FLAGS, 32'h0);
			check("flags", rd, {28'h0, ~m_tab[i][0], 3'b111});
		end
	endtask
	task automatic t_miss;
		wr(`TPW_OFF_CTRL, {19'h0, cw(4'hE, 2'h0, 2'h0, 3'h1)});
		wr(`TPW_OFF_CAPTOP, 32'h7);
		wr(`TPW_OFF_COUNT, 32'h100);
		bus(1'b0, `TPW_OFF_COUNT, 32'h0);
		check("count past top", {24'h0, rd[15:8]}, 32'h1);
		wr(`TPW_OFF_COUNT, 32'h0);
	endtask
	task automatic t_mask;
		for (int m = 1; m < 8; m++) begin
			if (m != 4) begin
				wr(`TPW_OFF_CTRL, {19'h0, cw(4'(m), 2'h0, 2'h0, 3'h0)});
				wr(`TPW_OFF_CMP_A, 32'hFFFF);
				bus(1'b0, `TPW_OFF_CMP_A, 32'h0);
				check("masked compare", rd, {16'h0, (16'h0080 << m[1:0]) - 16'h0001});
				// idle so the stopped-clock checker sees a settled window
				repeat (6) @(posedge sys_clk);
			end
		end
	endtask
	initial begin
		arst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		clr = 1'b0;
		run = 1'b0;
		err_total = 0;
		cmp_count = 0;
		repeat (12) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		t_reset;
		t_fast;
		t_dual;
		t_tog;
		t_flags;
		t_pre;
		t_miss;
		t_mask;
		give_verdict;
	end
endmodule // tb_timer16_pwm_waveform_modes
`default_nettype wire
